// File: pkg/cmop_pkg.sv
// constants and types shared by the message object page design
package cmop_pkg;
  localparam int          NUM_OBJ       = 15;
  localparam int          OBJ_W         = 4;
  localparam int          ADDR_W        = 8;
  // register byte offsets on the bus
  localparam logic [7:0]  OFS_PAGE      = 8'h00;
  localparam logic [7:0]  OFS_STAT      = 8'h04;
  localparam logic [7:0]  OFS_CTRL      = 8'h08;
  localparam logic [7:0]  OFS_TAG1      = 8'h0C;
  localparam logic [7:0]  OFS_TAG2      = 8'h10;
  localparam logic [7:0]  OFS_TAG3      = 8'h14;
  localparam logic [7:0]  OFS_TAG4      = 8'h18;
  localparam logic [7:0]  OFS_MSK1      = 8'h1C;
  localparam logic [7:0]  OFS_MSK2      = 8'h20;
  localparam logic [7:0]  OFS_MSK3      = 8'h24;
  localparam logic [7:0]  OFS_MSK4      = 8'h28;
  localparam logic [7:0]  OFS_STML      = 8'h2C;
  localparam logic [7:0]  OFS_STMH      = 8'h30;
  localparam logic [7:0]  OFS_MSG       = 8'h34;
  // page select fields
  localparam int          PAGE_OBJ_LSB  = 4;
  localparam int          PAGE_INDEX_AUTOINC_N_BIT = 3;
  localparam logic [7:0]  PAGE_RST      = 8'h00;
  // control and status fields
  localparam int          CTRL_CONF_LSB = 6;
  localparam int          CTRL_REPLY_VALID_BIT = 5;
  localparam int          CTRL_IDE_BIT  = 4;
  localparam int          STAT_LENW_BIT = 7;
  localparam int          STAT_RXOK_BIT = 5;
  localparam logic [3:0]  DLC_MAX       = 4'h8;
  // tag and mask fields
  localparam int          TAG_RTR_BIT   = 2;
  localparam int          MSK_IDE_BIT   = 0;
  localparam logic [31:0] ID_FIELD_EXT  = 32'hFFFF_FFF8;
  localparam logic [31:0] ID_FIELD_BASE = 32'hFFE0_0000;
  // bus responses
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;

  typedef enum logic [1:0] {
    CONF_OFF  = 2'b00,
    CONF_TX   = 2'b01,
    CONF_RX   = 2'b10,
    CONF_FBUF = 2'b11
  } cmop_conf_t;
endpackage

// File: src/cmop_accept.sv
// acceptance comparison of one message object against a received frame
`timescale 1ns/1ps
module cmop_accept (
  input  wire logic        enable_in,  // object is a receiver
  input  wire logic [31:0] tag_in,     // stored identifier tag
  input  wire logic [31:0] mask_in,    // stored acceptance mask
  input  wire logic        ide_in,     // stored extension bit
  input  wire logic [31:0] rx_tag_in,  // received tag
  input  wire logic        rx_ide_in,  // received extension bit
  output logic             match_out   // frame accepted
);
  logic [31:0] field;
  logic [31:0] keep;
  logic        id_ok;
  logic        ide_ok;

  // base format leaves bits 20:3 and 1:0 out of the compare
  assign field  = ide_in ? cmop_pkg::ID_FIELD_EXT
                         : cmop_pkg::ID_FIELD_BASE;
  assign keep   = mask_in & (field | (32'h0000_0001 << cmop_pkg::TAG_RTR_BIT));
  assign id_ok  = ~|((tag_in ^ rx_tag_in) & keep);
  assign ide_ok = ~(mask_in[cmop_pkg::MSK_IDE_BIT] & (ide_in ^ rx_ide_in));
  assign match_out = enable_in & id_ok & ide_ok;
endmodule

// File: src/cmop_sync.sv
// two-stage reset release synchroniser
`timescale 1ns/1ps
module cmop_sync (
  input  wire logic clk_in,     // system clock
  input  wire logic resetn_in,  // asynchronous reset, active low
  output logic      resetn_out  // synchronised release, active low
);
  logic stage1_reg;
  logic stage2_reg;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
    end else begin
      stage1_reg <= 1'b1;
      stage2_reg <= stage1_reg;
    end
  end

  assign resetn_out = stage2_reg;
endmodule

// File: src/cmop_top.sv
// message object page: register file, acceptance and frame data hand-off
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module cmop_top (
  input  wire logic        CLK_SYS_IN,          // 25 MHz system clock
  input  wire logic        RESETN_IN,           // async reset, active low
  input  wire logic [7:0]  S_AXI_AWADDR_IN,     // write address
  input  wire logic        S_AXI_AWVALID_IN,    // write address valid
  output logic             S_AXI_AWREADY_OUT,   // write address ready
  input  wire logic [31:0] S_AXI_WDATA_IN,      // write data
  input  wire logic [3:0]  S_AXI_WSTRB_IN,      // write strobes
  input  wire logic        S_AXI_WVALID_IN,     // write data valid
  output logic             S_AXI_WREADY_OUT,    // write data ready
  output logic [1:0]       S_AXI_BRESP_OUT,     // write response
  output logic             S_AXI_BVALID_OUT,    // write response valid
  input  wire logic        S_AXI_BREADY_IN,     // write response ready
  input  wire logic [7:0]  S_AXI_ARADDR_IN,     // read address
  input  wire logic        S_AXI_ARVALID_IN,    // read address valid
  output logic             S_AXI_ARREADY_OUT,   // read address ready
  output logic [31:0]      S_AXI_RDATA_OUT,     // read data
  output logic [1:0]       S_AXI_RRESP_OUT,     // read response
  output logic             S_AXI_RVALID_OUT,    // read data valid
  input  wire logic        S_AXI_RREADY_IN,     // read data ready
  input  wire logic        RX_VALID_IN,         // received frame pulse
  input  wire logic [31:0] RX_TAG_IN,           // received tag image
  input  wire logic        RX_IDE_IN,           // received extension bit
  input  wire logic [3:0]  RX_DLC_IN,           // received length code
  input  wire logic [63:0] RX_DATA_IN,          // received bytes, 0 low
  input  wire logic [15:0] RX_STAMP_IN,         // time stamp of frame
  output logic             RX_HIT_OUT,          // frame stored pulse
  output logic [3:0]       RX_HIT_OBJ_OUT,      // object that took it
  input  wire logic [3:0]  TX_OBJ_IN,           // object to transmit
  input  wire logic        TX_REPLY_IN,         // automatic reply frame
  input  wire logic        TX_START_IN,         // frame start pulse
  output logic [31:0]      TX_TAG_OUT,          // tag to send
  output logic             TX_IDE_OUT,          // extended format
  output logic [3:0]       TX_DLC_OUT,          // effective length
  output logic [63:0]      TX_DATA_OUT,         // bytes to send
  output logic             TX_REPLY_VALID_OUT   // reply may be sent
);
  localparam int N = cmop_pkg::NUM_OBJ;

  logic        rst_n;
  logic [31:0] tag_reg   [N];
  logic [31:0] tag_next  [N];
  logic [31:0] mask_reg  [N];
  logic [31:0] mask_next [N];
  logic [7:0]  ctrl_reg  [N];
  logic [7:0]  ctrl_next [N];
  logic [7:0]  stat_reg  [N];
  logic [7:0]  stat_next [N];
  logic [15:0] stamp_reg [N];
  logic [15:0] stamp_next[N];
  logic [63:0] msg_reg   [N];
  logic [63:0] msg_next  [N];
  logic [7:0]  page_reg, page_next;
  logic        aw_held_reg, aw_held_next;
  logic [7:0]  awaddr_reg, awaddr_next;
  logic        w_held_reg, w_held_next;
  logic [7:0]  wdata_reg, wdata_next;
  logic        wstrb_reg, wstrb_next;
  logic        bvalid_reg, bvalid_next;
  logic [1:0]  bresp_reg, bresp_next;
  logic        rvalid_reg, rvalid_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic [1:0]  rresp_reg, rresp_next;
  logic        hit_reg, hit_next;
  logic [3:0]  hit_obj_reg, hit_obj_next;
  logic [31:0] tx_tag_reg, tx_tag_next;
  logic        tx_ide_reg, tx_ide_next;
  logic [3:0]  tx_dlc_reg, tx_dlc_next;
  logic [63:0] tx_data_reg, tx_data_next;
  logic        tx_reply_valid_reg, tx_reply_valid_next;
  logic [N-1:0] match;
  logic [3:0]  sel;
  logic [2:0]  idx;
  logic        sel_ok;
  logic        aw_have, w_have, do_write, do_read;
  logic [7:0]  wr_addr, wr_byte;
  logic        wr_en, wr_map, rd_map, rd_inc, wr_inc;
  logic        rx_any;
  logic [3:0]  rx_obj;

  cmop_sync u_sync (
    .clk_in     (CLK_SYS_IN),
    .resetn_in  (RESETN_IN),
    .resetn_out (rst_n)
  );

  assign sel    = page_reg[7:cmop_pkg::PAGE_OBJ_LSB];
  assign idx    = page_reg[2:0];
  assign sel_ok = sel < 4'(N);

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_acc
      cmop_accept u_acc (
        .enable_in (RX_VALID_IN &
                    ctrl_reg[g][7:cmop_pkg::CTRL_CONF_LSB] >=
                    cmop_pkg::CONF_RX),
        .tag_in    (tag_reg[g]),
        .mask_in   (mask_reg[g]),
        .ide_in    (ctrl_reg[g][cmop_pkg::CTRL_IDE_BIT]),
        .rx_tag_in (RX_TAG_IN),
        .rx_ide_in (RX_IDE_IN),
        .match_out (match[g])
      );
    end
  endgenerate

  // lowest object number takes the frame
  always_comb begin
    rx_any = 1'b0;
    rx_obj = 4'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (match[i]) begin
        rx_any = 1'b1;
        rx_obj = 4'(i);
      end
    end
  end

  function automatic logic mapped(input logic [7:0] a);
    case (a)
      cmop_pkg::OFS_PAGE, cmop_pkg::OFS_STAT, cmop_pkg::OFS_CTRL,
      cmop_pkg::OFS_TAG1, cmop_pkg::OFS_TAG2, cmop_pkg::OFS_TAG3,
      cmop_pkg::OFS_TAG4, cmop_pkg::OFS_MSK1, cmop_pkg::OFS_MSK2,
      cmop_pkg::OFS_MSK3, cmop_pkg::OFS_MSK4, cmop_pkg::OFS_STML,
      cmop_pkg::OFS_STMH, cmop_pkg::OFS_MSG: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  assign S_AXI_AWREADY_OUT = !aw_held_reg && !bvalid_reg;
  assign S_AXI_WREADY_OUT  = !w_held_reg && !bvalid_reg;
  assign S_AXI_ARREADY_OUT = !rvalid_reg;
  assign aw_have  = aw_held_reg || S_AXI_AWVALID_IN;
  assign w_have   = w_held_reg || S_AXI_WVALID_IN;
  assign do_write = aw_have && w_have && !bvalid_reg;
  assign do_read  = S_AXI_ARVALID_IN && !rvalid_reg;
  assign wr_addr  = aw_held_reg ? awaddr_reg : S_AXI_AWADDR_IN;
  assign wr_byte  = w_held_reg ? wdata_reg : S_AXI_WDATA_IN[7:0];
  assign wr_map   = mapped(wr_addr);
  assign rd_map   = mapped(S_AXI_ARADDR_IN);
  assign wr_en    = do_write && wr_map &&
                    (w_held_reg ? wstrb_reg : S_AXI_WSTRB_IN[0]);
  assign rd_inc   = do_read && S_AXI_ARADDR_IN == cmop_pkg::OFS_MSG;
  assign wr_inc   = wr_en && wr_addr == cmop_pkg::OFS_MSG;

  // bus handshake and read data
  always_comb begin
    aw_held_next = aw_held_reg;
    awaddr_next  = awaddr_reg;
    w_held_next  = w_held_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg && !S_AXI_BREADY_IN;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg && !S_AXI_RREADY_IN;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
      aw_held_next = 1'b1;
      awaddr_next  = S_AXI_AWADDR_IN;
    end
    if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
      w_held_next = 1'b1;
      wdata_next  = S_AXI_WDATA_IN[7:0];
      wstrb_next  = S_AXI_WSTRB_IN[0];
    end
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = wr_map ? cmop_pkg::RESP_OKAY : cmop_pkg::RESP_SLVERR;
    end
    if (do_read) begin
      rvalid_next = 1'b1;
      rresp_next  = rd_map ? cmop_pkg::RESP_OKAY : cmop_pkg::RESP_SLVERR;
      rdata_next  = 8'h00;
      if (S_AXI_ARADDR_IN == cmop_pkg::OFS_PAGE) begin
        rdata_next = page_reg;
      end else if (sel_ok) begin
        case (S_AXI_ARADDR_IN)
          cmop_pkg::OFS_STAT: rdata_next = stat_reg[sel];
          cmop_pkg::OFS_CTRL: rdata_next = ctrl_reg[sel];
          cmop_pkg::OFS_TAG1: rdata_next = tag_reg[sel][31:24];
          cmop_pkg::OFS_TAG2: rdata_next = tag_reg[sel][23:16];
          cmop_pkg::OFS_TAG3: rdata_next = tag_reg[sel][15:8];
          cmop_pkg::OFS_TAG4: rdata_next = tag_reg[sel][7:0];
          cmop_pkg::OFS_MSK1: rdata_next = mask_reg[sel][31:24];
          cmop_pkg::OFS_MSK2: rdata_next = mask_reg[sel][23:16];
          cmop_pkg::OFS_MSK3: rdata_next = mask_reg[sel][15:8];
          cmop_pkg::OFS_MSK4: rdata_next = mask_reg[sel][7:0];
          cmop_pkg::OFS_STML: rdata_next = stamp_reg[sel][7:0];
          cmop_pkg::OFS_STMH: rdata_next = stamp_reg[sel][15:8];
          cmop_pkg::OFS_MSG:  rdata_next = msg_reg[sel][idx*8 +: 8];
          default:            rdata_next = 8'h00;
        endcase
      end
    end
  end

  // object storage, page and frame hand-off
  always_comb begin
    tag_next   = tag_reg;
    mask_next  = mask_reg;
    ctrl_next  = ctrl_reg;
    stat_next  = stat_reg;
    stamp_next = stamp_reg;
    msg_next   = msg_reg;
    page_next  = page_reg;
    if (wr_en && wr_addr == cmop_pkg::OFS_PAGE) begin
      page_next = wr_byte;
    end else if (wr_en && sel_ok) begin
      case (wr_addr)
        cmop_pkg::OFS_STAT: stat_next[sel] = wr_byte;
        cmop_pkg::OFS_CTRL: ctrl_next[sel] = wr_byte;
        cmop_pkg::OFS_TAG1: tag_next[sel][31:24] = wr_byte;
        cmop_pkg::OFS_TAG2: tag_next[sel][23:16] = wr_byte;
        cmop_pkg::OFS_TAG3: tag_next[sel][15:8] = wr_byte;
        cmop_pkg::OFS_TAG4: tag_next[sel][7:0] = wr_byte;
        cmop_pkg::OFS_MSK1: mask_next[sel][31:24] = wr_byte;
        cmop_pkg::OFS_MSK2: mask_next[sel][23:16] = wr_byte;
        cmop_pkg::OFS_MSK3: mask_next[sel][15:8] = wr_byte;
        cmop_pkg::OFS_MSK4: mask_next[sel][7:0] = wr_byte;
        cmop_pkg::OFS_MSG:  msg_next[sel][idx*8 +: 8] = wr_byte;
        default: ;
      endcase
    end
    // index advances after the access that used it, modulo eight
    if (!page_reg[cmop_pkg::PAGE_INDEX_AUTOINC_N_BIT]) begin
      page_next[2:0] = page_next[2:0] + 3'(rd_inc) + 3'(wr_inc);
    end
    if (TX_START_IN && TX_REPLY_IN && TX_OBJ_IN < 4'(N)) begin
      tag_next[TX_OBJ_IN][cmop_pkg::TAG_RTR_BIT] = 1'b0;
    end
    // a frame landing with a software write wins over it
    if (rx_any) begin
      tag_next[rx_obj] = RX_TAG_IN;
      ctrl_next[rx_obj][cmop_pkg::CTRL_IDE_BIT] = RX_IDE_IN;
      ctrl_next[rx_obj][3:0] = RX_DLC_IN;
      stat_next[rx_obj][cmop_pkg::STAT_RXOK_BIT] = 1'b1;
      if (RX_DLC_IN != ctrl_reg[rx_obj][3:0]) begin
        stat_next[rx_obj][cmop_pkg::STAT_LENW_BIT] = 1'b1;
      end
      stamp_next[rx_obj] = RX_STAMP_IN;
      msg_next[rx_obj]   = RX_DATA_IN;
    end
  end

  always_comb begin
    hit_next     = rx_any;
    hit_obj_next = rx_obj;
    tx_tag_next  = 32'h0000_0000;
    tx_ide_next  = 1'b0;
    tx_dlc_next  = 4'h0;
    tx_data_next = 64'h0000_0000_0000_0000;
    tx_reply_valid_next = 1'b0;
    if (TX_OBJ_IN < 4'(N)) begin
      tx_tag_next = tag_reg[TX_OBJ_IN];
      if (TX_REPLY_IN) begin
        tx_tag_next[cmop_pkg::TAG_RTR_BIT] = 1'b0;
      end
      tx_ide_next  = ctrl_reg[TX_OBJ_IN][cmop_pkg::CTRL_IDE_BIT];
      tx_dlc_next  = ctrl_reg[TX_OBJ_IN][3:0] > cmop_pkg::DLC_MAX ?
                     cmop_pkg::DLC_MAX : ctrl_reg[TX_OBJ_IN][3:0];
      tx_data_next = msg_reg[TX_OBJ_IN];
      tx_reply_valid_next = ctrl_reg[TX_OBJ_IN][cmop_pkg::CTRL_REPLY_VALID_BIT];
    end
  end

  // object storage carries no reset value
  always_ff @(posedge CLK_SYS_IN) begin
    tag_reg   <= tag_next;
    mask_reg  <= mask_next;
    ctrl_reg  <= ctrl_next;
    stat_reg  <= stat_next;
    stamp_reg <= stamp_next;
    msg_reg   <= msg_next;
  end

  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      page_reg    <= cmop_pkg::PAGE_RST;
      aw_held_reg <= 1'b0;
      awaddr_reg  <= 8'h00;
      w_held_reg  <= 1'b0;
      wdata_reg   <= 8'h00;
      wstrb_reg   <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= cmop_pkg::RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 8'h00;
      rresp_reg   <= cmop_pkg::RESP_OKAY;
      hit_reg     <= 1'b0;
      hit_obj_reg <= 4'h0;
      tx_tag_reg  <= 32'h0000_0000;
      tx_ide_reg  <= 1'b0;
      tx_dlc_reg  <= 4'h0;
      tx_data_reg <= 64'h0000_0000_0000_0000;
      tx_reply_valid_reg <= 1'b0;
    end else begin
      page_reg    <= page_next;
      aw_held_reg <= aw_held_next;
      awaddr_reg  <= awaddr_next;
      w_held_reg  <= w_held_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
      hit_reg     <= hit_next;
      hit_obj_reg <= hit_obj_next;
      tx_tag_reg  <= tx_tag_next;
      tx_ide_reg  <= tx_ide_next;
      tx_dlc_reg  <= tx_dlc_next;
      tx_data_reg <= tx_data_next;
      tx_reply_valid_reg <= tx_reply_valid_next;
    end
  end

  assign S_AXI_BVALID_OUT   = bvalid_reg;
  assign S_AXI_BRESP_OUT    = bresp_reg;
  assign S_AXI_RVALID_OUT   = rvalid_reg;
  assign S_AXI_RDATA_OUT    = {24'h00_0000, rdata_reg};
  assign S_AXI_RRESP_OUT    = rresp_reg;
  assign RX_HIT_OUT         = hit_reg;
  assign RX_HIT_OBJ_OUT     = hit_obj_reg;
  assign TX_TAG_OUT         = tx_tag_reg;
  assign TX_IDE_OUT         = tx_ide_reg;
  assign TX_DLC_OUT         = tx_dlc_reg;
  assign TX_DATA_OUT        = tx_data_reg;
  assign TX_REPLY_VALID_OUT = tx_reply_valid_reg;

  a_index_step: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n)
    (wr_inc && !rd_inc && !page_reg[3])
    |=> idx == 3'($past(idx) + 3'd1))
    else $error("byte index did not advance after port write");
  a_index_hold: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n)
    (page_reg[3] && !(wr_en && wr_addr == cmop_pkg::OFS_PAGE))
    |=> $stable(idx))
    else $error("byte index moved while auto-increment off");
  a_dlc_clamp: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n)
    (TX_OBJ_IN < 4'(N) && ctrl_reg[TX_OBJ_IN][3:0] > 4'h8)
    |=> TX_DLC_OUT == 4'h8)
    else $error("length code above eight not clamped");
  a_reply_rtr: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n)
    TX_REPLY_IN |=> !TX_TAG_OUT[2])
    else $error("remote bit set in automatic reply");
  a_rx_ide_load: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n)
    rx_any |=> RX_HIT_OUT && ctrl_reg[RX_HIT_OBJ_OUT][4] == $past(RX_IDE_IN))
    else $error("received extension bit not stored");
  a_rx_len_warn: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n)
    (rx_any && RX_DLC_IN != ctrl_reg[rx_obj][3:0])
    |=> stat_reg[RX_HIT_OBJ_OUT][7])
    else $error("length warning not raised");
  a_rx_tag_load: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n)
    rx_any |=> tag_reg[RX_HIT_OBJ_OUT] == $past(RX_TAG_IN))
    else $error("received tag not stored");
  a_hit_accept: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n)
    RX_HIT_OUT |-> $past(RX_VALID_IN) && $past(match[rx_obj]))
    else $error("frame stored without acceptance");
  a_reply_valid: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n)
    (TX_OBJ_IN < 4'(N)) |=> TX_REPLY_VALID_OUT == $past(ctrl_reg[TX_OBJ_IN][5]))
    else $error("reply valid not passed to transmitter");
endmodule

// File: testbench/cmop_can_node.sv
// far-side node model that presents received frames to the object page
`timescale 1ns/1ps
module cmop_can_node (
  input  wire logic  clk_in,    // system clock
  output logic       vld_out,   // frame pulse
  output logic [31:0] tag_out,  // frame tag image
  output logic       ide_out,   // extension bit
  output logic [3:0] dlc_out,   // length code
  output logic [63:0] data_out, // frame bytes
  output logic [15:0] stamp_out // frame time stamp
);
  initial {vld_out, tag_out, ide_out, dlc_out, data_out, stamp_out} = '0;
  task automatic send(input logic [31:0] t, input logic i,
                      input logic [3:0] d, input logic [63:0] b,
                      input logic [15:0] s);
    @(posedge clk_in);
    {tag_out, ide_out, dlc_out, data_out, stamp_out} <= {t, i, d, b, s};
    vld_out <= 1'b1;
    @(posedge clk_in);
    vld_out <= 1'b0;
    // stale fields are flipped so nothing relies on them after the pulse
    {tag_out, ide_out, dlc_out, data_out, stamp_out} <= ~{t, i, d, b, s};
  endtask
endmodule

// File: testbench/cmop_top_tb_top.sv
// self-checking bench for the message object page
`timescale 1ns/1ps
module cmop_top_tb_top;
  logic clk, rst_n, awv, wv, bready, arv, rready, txr, txs;
  logic [7:0]  awa, ara;
  logic [31:0] wd;
  logic [3:0]  txo;
  logic        awrdy, wrdy, bv, arrdy, rv, hit, txide, trv, rxv, rxide;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, txtag, rxtag;
  logic [3:0]  hobj, txdlc, rxdlc;
  logic [63:0] txdata, rxd, d;
  logic [15:0] rxs, s;
  logic [33:0] rq[$];
  logic [3:0]  hq[$];
  int          err_total, compares, cyc, seed;
  localparam logic [31:0] T = 32'hA5C0_0004;
  localparam logic [31:0] M = 32'hFFE0_0004;

  cmop_top DUT (.CLK_SYS_IN(clk), .RESETN_IN(rst_n), .S_AXI_AWADDR_IN(awa),
    .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awrdy), .S_AXI_WDATA_IN(wd),
    .S_AXI_WSTRB_IN(4'h1), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wrdy),
    .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(bready),
    .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arrdy),
    .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rv),
    .S_AXI_RREADY_IN(rready), .RX_VALID_IN(rxv), .RX_TAG_IN(rxtag),
    .RX_IDE_IN(rxide), .RX_DLC_IN(rxdlc), .RX_DATA_IN(rxd),
    .RX_STAMP_IN(rxs), .RX_HIT_OUT(hit), .RX_HIT_OBJ_OUT(hobj),
    .TX_OBJ_IN(txo), .TX_REPLY_IN(txr), .TX_START_IN(txs),
    .TX_TAG_OUT(txtag), .TX_IDE_OUT(txide), .TX_DLC_OUT(txdlc),
    .TX_DATA_OUT(txdata), .TX_REPLY_VALID_OUT(trv));
  cmop_can_node node (.clk_in(clk), .vld_out(rxv), .tag_out(rxtag),
    .ide_out(rxide), .dlc_out(rxdlc), .data_out(rxd), .stamp_out(rxs));

  task automatic results;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v,
                    input logic [1:0] r = cmop_pkg::RESP_OKAY);
    logic ta, tw, tbv;
    rq.push_back({r, 32'h0});
    @(posedge clk);
    {awa, wd, awv, wv, bready} <= {a, 24'h0, v, 3'b111};
    // handshakes are judged mid-cycle, where ready and valid are settled
    do begin
      @(negedge clk);
      {ta, tw, tbv} = {awv && awrdy, wv && wrdy, bv};
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end while (!tbv);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] v,
                    input logic [1:0] r = cmop_pkg::RESP_OKAY);
    logic ta, trv;
    rq.push_back({r, 24'h0, v});
    @(posedge clk);
    {ara, arv, rready} <= {a, 2'b11};
    do begin
      @(negedge clk);
      {ta, trv} = {arv && arrdy, rv};
      @(posedge clk);
      if (ta) arv <= 1'b0;
    end while (!trv);
    rready <= 1'b0;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // result watcher: every answer takes the oldest expected note
  always @(negedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      results();
    end
    if (bv && bready) chk({bresp, 32'h0}, rq.size() ? rq.pop_front() : 'x);
    if (rv && rready) chk({rresp, rdata}, rq.size() ? rq.pop_front() : 'x);
    if (hit) chk(hobj, hq.size() ? hq.pop_front() : 'x);
  end

  initial begin
    {rst_n, awv, wv, bready, arv, rready, txr, txs, awa, ara, wd} = '0;
    {err_total, compares, cyc, txo, seed} = {96'h0, 4'hF, 32'he5ee};
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    // park every object so no undefined one joins the compare
    for (int o = 0; o < 15; o++) begin
      wr(cmop_pkg::OFS_PAGE, 8'(o << 4));
      wr(cmop_pkg::OFS_CTRL, 8'h00);
    end
    wr(cmop_pkg::OFS_PAGE, 8'h20);
    wr(cmop_pkg::OFS_STAT, 8'h00);
    wr(cmop_pkg::OFS_CTRL, 8'hB2);
    for (int k = 0; k < 4; k++) begin
      wr(cmop_pkg::OFS_TAG1 + 8'(4 * k), T[31 - 8 * k -: 8]);
      wr(cmop_pkg::OFS_MSK1 + 8'(4 * k), M[31 - 8 * k -: 8]);
    end
    rd(cmop_pkg::OFS_TAG1, 8'hA5);
    $display("test setup done");
    hq.push_back(4'h2);
    node.send(T, 1'b0, 4'hA, {$random(seed), $random(seed)}, 16'h0);
    node.send(T ^ 32'h0020_0000, 1'b0, 4'hA, 64'h0, 16'h0);
    node.send(T ^ 32'h0000_0004, 1'b0, 4'hA, 64'h0, 16'h0);
    {d, s} = {$random(seed), $random(seed), 16'($random(seed))};
    hq.push_back(4'h2);
    node.send(T ^ 32'h0000_0010, 1'b0, 4'hA, d, s);
    repeat (2) @(posedge clk);
    rd(cmop_pkg::OFS_CTRL, 8'hAA);
    rd(cmop_pkg::OFS_STAT, 8'hA0);
    rd(cmop_pkg::OFS_STML, s[7:0]);
    rd(cmop_pkg::OFS_STMH, s[15:8]);
    $display("test receive done");
    wr(cmop_pkg::OFS_PAGE, 8'h26);
    rd(cmop_pkg::OFS_MSG, d[55:48]);
    rd(cmop_pkg::OFS_MSG, d[63:56]);
    rd(cmop_pkg::OFS_MSG, d[7:0]);
    wr(cmop_pkg::OFS_PAGE, 8'h2D);
    wr(cmop_pkg::OFS_MSG, 8'h5A);
    rd(cmop_pkg::OFS_MSG, 8'h5A);
    rd(cmop_pkg::OFS_MSG, 8'h5A);
    rd(8'hFC, 8'h00, cmop_pkg::RESP_SLVERR);
    wr(8'hFC, 8'h11, cmop_pkg::RESP_SLVERR);
    wr(cmop_pkg::OFS_STML, ~s[7:0]);
    rd(cmop_pkg::OFS_STML, s[7:0]);
    $display("test payload done");
    @(posedge clk);
    {txo, txr} <= {4'h2, 1'b1};
    repeat (2) @(posedge clk);
    chk({txtag, txide, txdlc, trv}, {(T ^ 32'h10) & ~32'h4, 6'b0_1000_1});
    chk(txdata, {d[63:48], 8'h5A, d[39:0]});
    txs <= 1'b1;
    @(posedge clk);
    {txs, txr} <= 2'b00;
    rd(cmop_pkg::OFS_TAG4, 8'h10);
    chk(32'(hq.size()), 32'h0);
    $display("test transmit done");
    results();
  end
endmodule
